// [sbg_consts.vh]
`ifndef SBG_CONSTS_VH
`define SBG_CONSTS_VH

// register indices on the plain register port
`define SBG_ADDR_W 4
`define SBG_REG_CTRL 4'h0
`define SBG_REG_DIV 4'h1
`define SBG_REG_STAT 4'h2
`define SBG_REG_INTC 4'h3
`define SBG_REG_MSTOP 4'h4

// control register fields
`define SBG_CTRL_CKS_LO 0
`define SBG_CTRL_CKS_HI 1
`define SBG_CTRL_EXTCLK 2
`define SBG_CTRL_START 3
`define SBG_CTRL_RIE 4

// interrupt controller register fields
`define SBG_INTC_IEN 0
`define SBG_INTC_PRI_LO 4
`define SBG_INTC_PRI_HI 7
`define SBG_INTC_IFLAG 8

// reset values
`define SBG_CTRL_RST 8'h00
`define SBG_DIV_RST 8'hff
`define SBG_INTC_RST 9'h000
`define SBG_MSTOP_RST 1'b1

// bits per transfer
`define SBG_BITS 4'h8
`define SBG_BITS_W 4

// prescaler counter width: largest prescale is 64
`define SBG_PRE_W 6

`endif

// [sbg_prescaler.v]
`timescale 1ns/100ps
`include "sbg_consts.vh"

module sbg_prescaler (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// control
	input wire run,
	input wire [1:0] sel,
	// one-cycle tick at the selected clock source rate
	output reg tick
);

	reg [`SBG_PRE_W-1:0] cnt_reg;
	reg [`SBG_PRE_W-1:0] cnt_next;
	reg [`SBG_PRE_W-1:0] mask;

	// prescale is 2^(2*sel): mask of low bits that must all be set
	always @* begin
		case (sel)
			2'h0: mask = 6'h00;
			2'h1: mask = 6'h03;
			2'h2: mask = 6'h0f;
			default: mask = 6'h3f;
		endcase
		cnt_next = run ? cnt_reg + 6'h01 : 6'h00;
	end

	// free counter restarts with each transfer so the first bit is full length
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 6'h00;
			tick <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick <= run && ((cnt_reg & mask) == mask);
		end
	end

endmodule

// [sbg_irq_gate.v]
`timescale 1ns/100ps
`include "sbg_consts.vh"

module sbg_irq_gate (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// request and its enables
	input wire req,
	input wire block_en,
	input wire ctrl_en,
	input wire [3:0] priority_lvl,
	input wire [3:0] cpu_level,
	input wire cpu_interrupt_mask_flag,
	// forwarded request
	output reg irq
);

	// all four conditions must hold; priority must exceed the cpu level
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= req && block_en && ctrl_en && (priority_lvl > cpu_level)
				&& cpu_interrupt_mask_flag;
		end
	end

endmodule

// [sbg_top.v]
// Operation
// - internal bit rate is source over 4(N+1)
// - source is clock divided by 1,4,16,64
// - external mode uses serial clock pin directly
// - module stop set on reset release
// - stopped block ignores writes, reads zero
// - interrupt needs block, controller, cpu enables
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "sbg_consts.vh"

module sbg_top (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// register port
	input wire [`SBG_ADDR_W-1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// serial clock pin, three signals
	input wire serial_clock_pin_in,
	output reg serial_clock_pin_out,
	output reg serial_clock_pin_oe,
	// bit timing
	output reg bit_tick,
	output reg xfer_busy,
	// interrupt side
	input wire [3:0] cpu_level,
	input wire cpu_interrupt_mask_flag,
	output reg irq_out
);

	// software state
	reg [7:0] ctrl_reg;
	reg [7:0] bit_rate_divisor_reg;
	reg [8:0] intc_reg;
	reg module_stop_control_reg;

	// engine state
	reg [7:0] div_cnt_reg;
	reg [1:0] phase_reg;
	reg [`SBG_BITS_W-1:0] bits_reg;
	reg ext_clk_d1_reg;
	reg ext_clk_d2_reg;
	reg done_reg;

	wire pre_tick;
	wire irq_w;
	wire ext_mode;
	wire access_ok;
	wire start_wr;
	wire ext_rise;

	assign ext_mode = ctrl_reg[`SBG_CTRL_EXTCLK];
	assign access_ok = !module_stop_control_reg;
	assign start_wr = reg_wr && access_ok && (reg_addr == `SBG_REG_CTRL)
		&& reg_wdata[`SBG_CTRL_START];

	// prescaled clock source, counting only while an internal transfer runs
	sbg_prescaler u_pre (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(xfer_busy && !ext_mode),
		.sel(ctrl_reg[`SBG_CTRL_CKS_HI:`SBG_CTRL_CKS_LO]),
		.tick(pre_tick)
	);

	// interrupt enable chain on the transfer-done request
	sbg_irq_gate u_irq (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.req(done_reg),
		.block_en(ctrl_reg[`SBG_CTRL_RIE]),
		.ctrl_en(intc_reg[`SBG_INTC_IEN]),
		.priority_lvl(intc_reg[`SBG_INTC_PRI_HI:`SBG_INTC_PRI_LO]),
		.cpu_level(cpu_level),
		.cpu_interrupt_mask_flag(cpu_interrupt_mask_flag),
		.irq(irq_w)
	);

	// module stop: stopped from reset until software clears it
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			module_stop_control_reg <= `SBG_MSTOP_RST;
		end else if (reg_wr && reg_addr == `SBG_REG_MSTOP) begin
			module_stop_control_reg <= reg_wdata[0];
		end
	end

	// block registers; the stop register itself stays reachable
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `SBG_CTRL_RST;
			bit_rate_divisor_reg <= `SBG_DIV_RST;
			intc_reg <= `SBG_INTC_RST;
		end else begin
			if (reg_wr && access_ok) begin
				case (reg_addr)
					`SBG_REG_CTRL: ctrl_reg <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
					`SBG_REG_DIV: bit_rate_divisor_reg <= reg_wdata[7:0];
					`SBG_REG_INTC: intc_reg[7:0] <= reg_wdata[7:0];
					default: ;
				endcase
			end
			// pending flag: set wins over a write-one clear
			if (done_reg) begin
				intc_reg[`SBG_INTC_IFLAG] <= 1'b1;
			end else if (reg_wr && access_ok && reg_addr == `SBG_REG_INTC
				&& reg_wdata[`SBG_INTC_IFLAG]) begin
				intc_reg[`SBG_INTC_IFLAG] <= 1'b0;
			end
		end
	end

	// read data one cycle after the strobe; stopped block reads zero
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == `SBG_REG_MSTOP) begin
				reg_rdata <= {15'h0000, module_stop_control_reg};
			end else if (!access_ok) begin
				reg_rdata <= 16'h0000;
			end else begin
				case (reg_addr)
					`SBG_REG_CTRL: reg_rdata <= {8'h00, ctrl_reg};
					`SBG_REG_DIV: reg_rdata <= {8'h00, bit_rate_divisor_reg};
					`SBG_REG_STAT: reg_rdata <= {12'h000, bits_reg[3:1], xfer_busy};
					`SBG_REG_INTC: reg_rdata <= {7'h00, intc_reg};
					default: reg_rdata <= 16'h0000;
				endcase
			end
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// synchroniser for the partner clock; resets to the pulled-up idle level
	// so no false rising edge follows reset
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_clk_d1_reg <= 1'b1;
			ext_clk_d2_reg <= 1'b1;
		end else begin
			ext_clk_d1_reg <= serial_clock_pin_in;
			ext_clk_d2_reg <= ext_clk_d1_reg;
		end
	end

	reg ext_clk_d3_reg;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_clk_d3_reg <= 1'b1;
		end else begin
			ext_clk_d3_reg <= ext_clk_d2_reg;
		end
	end
	assign ext_rise = ext_clk_d2_reg && !ext_clk_d3_reg;

	// bit engine: four phases of (N+1) source ticks make one bit
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= 8'h00;
			phase_reg <= 2'h0;
			bits_reg <= 4'h0;
			xfer_busy <= 1'b0;
			bit_tick <= 1'b0;
			done_reg <= 1'b0;
			serial_clock_pin_out <= 1'b1;
			serial_clock_pin_oe <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			bit_tick <= 1'b0;
			done_reg <= 1'b0;
			irq_out <= irq_w;
			serial_clock_pin_oe <= !ext_mode && !module_stop_control_reg;
			if (start_wr && !xfer_busy) begin
				xfer_busy <= 1'b1;
				bits_reg <= `SBG_BITS;
				div_cnt_reg <= 8'h00;
				phase_reg <= 2'h0;
			end else if (xfer_busy && ext_mode) begin
				if (ext_rise) begin
					bit_tick <= 1'b1;
					bits_reg <= bits_reg - 4'h1;
					if (bits_reg == 4'h1) begin
						xfer_busy <= 1'b0;
						done_reg <= 1'b1;
					end
				end
			end else if (xfer_busy && pre_tick) begin
				if (div_cnt_reg == bit_rate_divisor_reg) begin
					div_cnt_reg <= 8'h00;
					phase_reg <= phase_reg + 2'h1;
					// low for two phases, high for two: one clock per bit
					if (phase_reg == 2'h0) begin
						serial_clock_pin_out <= 1'b0;
					end
					if (phase_reg == 2'h2) begin
						serial_clock_pin_out <= 1'b1;
					end
					if (phase_reg == 2'h3) begin
						bit_tick <= 1'b1;
						bits_reg <= bits_reg - 4'h1;
						if (bits_reg == 4'h1) begin
							xfer_busy <= 1'b0;
							done_reg <= 1'b1;
						end
					end
				end else begin
					div_cnt_reg <= div_cnt_reg + 8'h01;
				end
			end
		end
	end

endmodule

// [sbg_chk_assertions.sv]
`timescale 1ns/100ps
`include "sbg_consts.vh"
module sbg_chk (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// register port
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	// serial side
	input wire serial_clock_pin_oe,
	input wire bit_tick,
	input wire xfer_busy,
	// interrupt side
	input wire [3:0] cpu_level,
	input wire cpu_interrupt_mask_flag,
	input wire irq_out
);
	reg stop_q;
	reg [4:0] ctl_q;
	reg [7:0] div_q;
	reg [7:0] ic_q;
	reg [16:0] cnt;
	reg seen;
	wire ok = reg_wr && !stop_q;
	wire [16:0] per = ({9'h0, div_q} + 17'h1) << (2 + 2 * ctl_q[1:0]);
	// software view of settings; writes while stopped are dropped, except to the stop register
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_q <= 1'b1;
			ctl_q <= 5'h00;
			div_q <= 8'hff;
			ic_q <= 8'h00;
			cnt <= 17'h0;
			seen <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `SBG_REG_MSTOP)
				stop_q <= reg_wdata[0];
			if (ok && reg_addr == `SBG_REG_CTRL)
				ctl_q <= reg_wdata[4:0];
			if (ok && reg_addr == `SBG_REG_DIV)
				div_q <= reg_wdata[7:0];
			if (ok && reg_addr == `SBG_REG_INTC)
				ic_q <= reg_wdata[7:0];
			cnt <= bit_tick ? 17'h0 : cnt + 17'h1;
			seen <= xfer_busy && (seen || bit_tick);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	rate_int_a: assert property (bit_tick && seen && ctl_q[2:0] == 3'h0 |->
		cnt == per - 17'h1) else $error("bit period wrong");
	src_div_a: assert property (bit_tick && seen && !ctl_q[2] && ctl_q[1:0] != 2'h0 |->
		cnt == per - 17'h1) else $error("prescaled period wrong");
	ext_pin_a: assert property (ctl_q[2] && $past(ctl_q[2]) |-> !serial_clock_pin_oe)
		else $error("pin driven in external mode");
	stop_rd_a: assert property (reg_rd && reg_addr == `SBG_REG_MSTOP |=>
		reg_rdata == {15'h0, stop_q}) else $error("stop flag wrong");
	stop_zero_a: assert property (reg_rd && stop_q && reg_addr != `SBG_REG_MSTOP |=>
		reg_rdata == 16'h0000) else $error("stopped read not zero");
	irq_gate_a: assert property (irq_out |-> ctl_q[4] && ic_q[0] && ic_q[7:4] > $past(cpu_level)
		&& $past(cpu_interrupt_mask_flag)) else $error("request not gated");
	pin_drive_a: assert property (bit_tick && !ctl_q[2] |-> serial_clock_pin_oe)
		else $error("pin idle during bit");
	cover property (irq_out);
	cover property ($fell(xfer_busy) && ctl_q[2]);
	cover property (bit_tick && ctl_q[1:0] == 2'h3);
endmodule
bind sbg_top sbg_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.serial_clock_pin_oe(serial_clock_pin_oe), .bit_tick(bit_tick), .xfer_busy(xfer_busy),
	.cpu_level(cpu_level), .cpu_interrupt_mask_flag(cpu_interrupt_mask_flag), .irq_out(irq_out));

// [sbg_peer.sv]
`timescale 1ns/100ps
module sbg_peer (
	// frame request and clock half period
	input wire go,
	input wire [7:0] half,
	// pin drive, released between frames
	output reg clk_out,
	output reg oe
);
	integer i;
	// eight clocks per frame; clock stands still outside frames
	always @(posedge go) begin
		oe = 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			clk_out = 1'b0;
			#(half);
			clk_out = 1'b1;
			#(half);
		end
		oe = 1'b0;
	end
	initial begin
		oe = 1'b0;
		clk_out = 1'b1;
	end
endmodule

// [tb.sv]
`timescale 1ns/100ps
`include "sbg_consts.vh"
module tb;
	reg ref_clk, rst_n, reg_wr, reg_rd, flag, go, ext, rd_d, busy_d;
	reg [3:0] reg_addr, cpu_level;
	reg [15:0] reg_wdata;
	reg [7:0] half;
	wire [15:0] reg_rdata;
	wire p_clk, p_oe, pin_out, pin_oe, bit_tick, xfer_busy, irq_out;
	integer num_errors, n_checks, seed, cyc, last, ntk, nirq, k, n, e;
	reg [15:0] rq[$];
	integer per_q[$];
	// pin pulled high when nobody drives it
	wire pin = pin_oe ? pin_out : (p_oe ? p_clk : 1'b1);
	sbg_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_clock_pin_in(pin), .serial_clock_pin_out(pin_out),
		.serial_clock_pin_oe(pin_oe), .bit_tick(bit_tick), .xfer_busy(xfer_busy),
		.cpu_level(cpu_level), .cpu_interrupt_mask_flag(flag), .irq_out(irq_out));
	sbg_peer peer (.go(go), .half(half), .clk_out(p_clk), .oe(p_oe));
	task check(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task close_out;
		begin
			if (num_errors == 0 && n_checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// one gap cycle after each strobe so no signal is set twice at an edge
	task wr(input [3:0] a, input [15:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task rd(input [3:0] a, input [15:0] x);
		begin
			rq.push_back(x);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task wait_idle;
		integer t;
		begin
			repeat (3) @(posedge ref_clk);
			check(xfer_busy, 1);
			for (t = 0; t < 20000 && xfer_busy !== 1'b0; t = t + 1)
				@(posedge ref_clk);
			check(xfer_busy, 0);
			repeat (4) @(posedge ref_clk);
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// result watcher: read data, bit spacing and count, interrupts
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		rd_d <= reg_rd;
		busy_d <= xfer_busy;
		if (rd_d)
			check(reg_rdata, rq.pop_front());
		if (irq_out)
			nirq <= nirq + 1;
		if (bit_tick) begin
			if (ntk != 0 && !ext)
				check(cyc - last, per_q[0]);
			if (!ext)
				check(pin_out, 1);
			last <= cyc;
			ntk <= ntk + 1;
		end
		if (busy_d && !xfer_busy) begin
			check(ntk + bit_tick, 8);
			ntk <= 0;
			if (!ext)
				per_q.delete(0);
		end
	end
	initial begin
		#240000;
		num_errors = num_errors + 1;
		close_out;
	end
	initial begin
		{num_errors, n_checks, cyc, last, ntk, nirq} = 0;
		{rst_n, reg_wr, reg_rd, flag, go, ext, rd_d, busy_d} = 0;
		{reg_addr, cpu_level, reg_wdata} = 0;
		half = 8'd20;
		seed = 32'h3a87;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		wr(`SBG_REG_DIV, 16'h0003);
		rd(`SBG_REG_DIV, 16'h0000);
		rd(`SBG_REG_MSTOP, 16'h0001);
		wr(`SBG_REG_MSTOP, 16'h0000);
		rd(`SBG_REG_MSTOP, 16'h0000);
		rd(`SBG_REG_DIV, 16'h00ff);
		rd(4'h7, 16'h0000);
		// every source select; largest divisor on the undivided source
		for (k = 0; k < 4; k = k + 1) begin
			n = (k == 0) ? 255 : ($random(seed) & 3);
			wr(`SBG_REG_DIV, n[15:0]);
			per_q.push_back((4 * (n + 1)) << (2 * k));
			wr(`SBG_REG_CTRL, 16'h0018 | k[15:0]);
			wait_idle;
		end
		// external clock, fast then slow peer
		ext = 1'b1;
		for (k = 0; k < 2; k = k + 1) begin
			half <= k ? 8'd60 : 8'd20;
			wr(`SBG_REG_CTRL, 16'h000c);
			go <= 1'b1;
			wait_idle;
			go <= 1'b0;
		end
		ext = 1'b0;
		// interrupt forwarding: mask off, level too high, allowed
		wr(`SBG_REG_DIV, 16'h0000);
		wr(`SBG_REG_INTC, 16'h0051);
		for (k = 0; k < 3; k = k + 1) begin
			flag <= (k != 0);
			cpu_level <= (k == 1) ? 4'h5 : 4'h4;
			e = nirq + (k == 2);
			per_q.push_back(4);
			wr(`SBG_REG_CTRL, 16'h0018);
			wait_idle;
			check(nirq, e);
		end
		rd(`SBG_REG_STAT, 16'h0000);
		rd(`SBG_REG_INTC, 16'h0151);
		repeat (2) @(posedge ref_clk);
		close_out;
	end
endmodule
